/* File: sscs_pkg.sv */
// Package: register map, fields, modes and timing for the sync scheduler
package sscs_pkg;
  // Byte addresses of the registers
  localparam logic [11:0] SSCS_A_SYNC_TYPE  = 12'h000;
  localparam logic [11:0] SSCS_A_CYCLE_TIME = 12'h004;
  localparam logic [11:0] SSCS_A_OUT_SHIFT  = 12'h008;
  localparam logic [11:0] SSCS_A_IN_SHIFT   = 12'h00C;
  localparam logic [11:0] SSCS_A_OUT_COPY   = 12'h010;
  localparam logic [11:0] SSCS_A_IN_COPY    = 12'h014;
  localparam logic [11:0] SSCS_A_OUT_LAG    = 12'h018;
  localparam logic [11:0] SSCS_A_IN_LAG     = 12'h01C;
  localparam logic [11:0] SSCS_A_MIN_CYCLE  = 12'h020;
  localparam logic [11:0] SSCS_A_SUPPORTED  = 12'h024;
  localparam logic [11:0] SSCS_A_STATUS     = 12'h028;
  localparam logic [11:0] SSCS_A_SYNC1_IVL  = 12'h984;
  // Sync type field positions in the sync type register
  localparam int SSCS_F_OUT_TYPE = 0;
  localparam int SSCS_F_IN_TYPE  = 8;
  // Sync type encodings
  localparam logic [7:0] SSCS_T_LOCAL = 8'h00;
  localparam logic [7:0] SSCS_T_BUF   = 8'h01;
  localparam logic [7:0] SSCS_T_DC    = 8'h02;
  localparam logic [7:0] SSCS_T_DC_S1 = 8'h03;
  // Supported-types bits
  localparam int SSCS_B_SUP_LOCAL = 0;
  localparam int SSCS_B_SUP_BUF   = 1;
  localparam int SSCS_B_SUP_DC    = 2;
  // Reset values
  localparam logic [31:0] SSCS_R_CYCLE = 32'h0000_03E8;
  localparam logic [31:0] SSCS_R_ZERO  = 32'h0000_0000;
  // Trigger sources
  typedef enum logic [2:0] {
    SSCS_SRC_NONE  = 3'h0,
    SSCS_SRC_TIMER = 3'h1,
    SSCS_SRC_OBUF  = 3'h2,
    SSCS_SRC_IBUF  = 3'h3,
    SSCS_SRC_SYNC0 = 3'h4
  } sscs_src_t;
endpackage

/* File: sscs_delay.sv */
// One-shot delay counter: fires a pulse a set number of cycles after start
`timescale 1ns/1ps
`default_nettype none
module sscs_delay #(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         start,
  input  wire logic [W-1:0] dly,
  output logic              fire
);
  logic [W-1:0] cnt_ff;
  logic         run_ff;

  initial
  begin
    if (W < 2) $error("sscs_delay: W too small");
  end

  // Zero delay fires in the cycle after start, like a delay of one
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
    end
    else if (start)
    begin
      cnt_ff <= (dly == '0) ? '0 : dly - 1'b1;
      run_ff <= 1'b1;
    end
    else if (run_ff)
    begin
      if (cnt_ff == '0)
        run_ff <= 1'b0;
      else
        cnt_ff <= cnt_ff - 1'b1;
    end
  end

  assign fire = run_ff && (cnt_ff == '0) && !start;
endmodule
`default_nettype wire

/* File: sscs_scheduler.sv */
// Slave sync cycle scheduler with Avalon-MM register slave
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Both types 0x02 select DC; 0x03 uses SYNC1
// - Buffer mode: output event, input event only without outputs
// - Offsets writable only with variable offset support
// - SYNC1 shift replaces offset with interval plus lag
// - Each trigger: read outputs, drive, mark valid
// - Inputs due within minimum cycle after trigger; a late input ready only sets the overrun flag
// - Output lag spans drive start to valid
// - Input lag spans latch start to latch done
// - Copy into input buffer only after latch
// - SYNC1 interval register, SYNC0 is reference
// - SYNC1 may delay latch or drive start
// - Offset is sync event to valid or latch
// - Local timer starts free-running cycles
// - Output copy time covers copy and calculation
// - Input copy time covers calculation and copy
// - Supported bits: 0 local timer, 1 buffer, 2 DC
// - Output type 0x01 selects output buffer event, or input buffer event without outputs
module sscs_scheduler
  import sscs_pkg::*;
#(
  parameter bit VAR_SHIFT   = 1'b1,
  parameter bit HAS_OUTPUTS = 1'b1,
  parameter bit S1_REPLACE  = 1'b1,
  parameter int TW          = 32
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        obuf_event,
  input  wire logic        ibuf_event,
  input  wire logic        sync0_in,
  input  wire logic        sync1_in,
  output logic             out_read_start,
  output logic             out_drive_start,
  output logic             out_valid,
  output logic             in_latch_start,
  output logic             in_latch_done,
  output logic             in_copy_start,
  output logic             in_data_ready,
  output logic             cycle_start
);
  initial
  begin
    if (TW != 32) $error("sscs_scheduler: TW must be 32");
  end

  // Registers
  logic [15:0] sync_type_ff;
  logic [31:0] cycle_time_ff, out_shift_ff, in_shift_ff;
  logic [31:0] out_copy_ff, in_copy_ff, out_lag_ff, in_lag_ff;
  logic [31:0] min_cycle_ff, sync1_ivl_ff;
  logic        ack_ff;
  logic [31:0] rdata_ff;
  // Snapshot taken at cycle start
  logic [7:0]  cur_otype_ff, cur_itype_ff;
  logic [31:0] cur_oshift_ff, cur_ishift_ff;
  logic [31:0] cur_ocopy_ff, cur_icopy_ff, cur_olag_ff, cur_ilag_ff;
  logic [31:0] cur_min_ff;
  logic        overrun_ff;

  // Synchronisers for pin inputs
  logic [1:0] s0_sy_ff, s1_sy_ff, ob_sy_ff, ib_sy_ff;
  logic       s0_d_ff, s1_d_ff, ob_d_ff, ib_d_ff;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      s0_sy_ff <= 2'h0;
      s1_sy_ff <= 2'h0;
      ob_sy_ff <= 2'h0;
      ib_sy_ff <= 2'h0;
      s0_d_ff  <= 1'b0;
      s1_d_ff  <= 1'b0;
      ob_d_ff  <= 1'b0;
      ib_d_ff  <= 1'b0;
    end
    else
    begin
      s0_sy_ff <= {s0_sy_ff[0], sync0_in};
      s1_sy_ff <= {s1_sy_ff[0], sync1_in};
      ob_sy_ff <= {ob_sy_ff[0], obuf_event};
      ib_sy_ff <= {ib_sy_ff[0], ibuf_event};
      s0_d_ff  <= s0_sy_ff[1];
      s1_d_ff  <= s1_sy_ff[1];
      ob_d_ff  <= ob_sy_ff[1];
      ib_d_ff  <= ib_sy_ff[1];
    end
  end

  logic s0_rise, s1_rise, ob_rise, ib_rise;
  assign s0_rise = s0_sy_ff[1] && !s0_d_ff;
  assign s1_rise = s1_sy_ff[1] && !s1_d_ff;
  assign ob_rise = ob_sy_ff[1] && !ob_d_ff;
  assign ib_rise = ib_sy_ff[1] && !ib_d_ff;

  // Avalon slave: one wait cycle, answer on the second
  logic acc, wr_hit;
  assign acc             = (avs_read || avs_write) && !ack_ff;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;
  assign wr_hit          = avs_write && ack_ff;
  assign avs_readdata    = rdata_ff;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    return r;
  endfunction

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ack_ff <= 1'b0;
    else
      ack_ff <= acc;
  end

  logic [31:0] supported;
  assign supported = 32'h0000_0007;

  logic [31:0] status;
  assign status = {29'h0, overrun_ff, cur_itype_ff == SSCS_T_DC_S1,
                   cur_otype_ff == SSCS_T_DC_S1};

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdata_ff <= SSCS_R_ZERO;
    else if (acc && avs_read)
    begin
      case (avs_address)
        SSCS_A_SYNC_TYPE:  rdata_ff <= {16'h0, sync_type_ff};
        SSCS_A_CYCLE_TIME: rdata_ff <= cycle_time_ff;
        SSCS_A_OUT_SHIFT:  rdata_ff <= out_shift_ff;
        SSCS_A_IN_SHIFT:   rdata_ff <= in_shift_ff;
        SSCS_A_OUT_COPY:   rdata_ff <= out_copy_ff;
        SSCS_A_IN_COPY:    rdata_ff <= in_copy_ff;
        SSCS_A_OUT_LAG:    rdata_ff <= out_lag_ff;
        SSCS_A_IN_LAG:     rdata_ff <= in_lag_ff;
        SSCS_A_MIN_CYCLE:  rdata_ff <= min_cycle_ff;
        SSCS_A_SUPPORTED:  rdata_ff <= supported;
        SSCS_A_STATUS:     rdata_ff <= status;
        SSCS_A_SYNC1_IVL:  rdata_ff <= sync1_ivl_ff;
        default:           rdata_ff <= SSCS_R_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      sync_type_ff  <= 16'h0000;
      cycle_time_ff <= SSCS_R_CYCLE;
      out_shift_ff  <= SSCS_R_ZERO;
      in_shift_ff   <= SSCS_R_ZERO;
      out_copy_ff   <= SSCS_R_ZERO;
      in_copy_ff    <= SSCS_R_ZERO;
      out_lag_ff    <= SSCS_R_ZERO;
      in_lag_ff     <= SSCS_R_ZERO;
      min_cycle_ff  <= SSCS_R_CYCLE;
      sync1_ivl_ff  <= SSCS_R_ZERO;
    end
    else if (wr_hit)
    begin
      case (avs_address)
        SSCS_A_SYNC_TYPE:
          sync_type_ff <= 16'(merge({16'h0, sync_type_ff}, avs_writedata,
                                    avs_byteenable));
        SSCS_A_CYCLE_TIME:
          cycle_time_ff <= merge(cycle_time_ff, avs_writedata,
                                 avs_byteenable);
        SSCS_A_OUT_SHIFT:
          if (VAR_SHIFT)
            out_shift_ff <= merge(out_shift_ff, avs_writedata,
                                  avs_byteenable);
        SSCS_A_IN_SHIFT:
          if (VAR_SHIFT)
            in_shift_ff <= merge(in_shift_ff, avs_writedata,
                                 avs_byteenable);
        SSCS_A_OUT_COPY:
          out_copy_ff <= merge(out_copy_ff, avs_writedata, avs_byteenable);
        SSCS_A_IN_COPY:
          in_copy_ff <= merge(in_copy_ff, avs_writedata, avs_byteenable);
        SSCS_A_OUT_LAG:
          out_lag_ff <= merge(out_lag_ff, avs_writedata, avs_byteenable);
        SSCS_A_IN_LAG:
          in_lag_ff <= merge(in_lag_ff, avs_writedata, avs_byteenable);
        SSCS_A_MIN_CYCLE:
          min_cycle_ff <= merge(min_cycle_ff, avs_writedata,
                                avs_byteenable);
        SSCS_A_SYNC1_IVL:
          sync1_ivl_ff <= merge(sync1_ivl_ff, avs_writedata,
                                avs_byteenable);
        default: ;
      endcase
    end
  end

  // Trigger source from live settings
  logic [7:0] otype, itype;
  logic       dc_mode;
  sscs_src_t  src;
  assign otype   = sync_type_ff[SSCS_F_OUT_TYPE +: 8];
  assign itype   = sync_type_ff[SSCS_F_IN_TYPE +: 8];
  assign dc_mode = (otype == SSCS_T_DC || otype == SSCS_T_DC_S1) &&
                   (itype == SSCS_T_DC || itype == SSCS_T_DC_S1);

  always_comb
  begin
    if (dc_mode)
      src = SSCS_SRC_SYNC0;
    else if (otype == SSCS_T_BUF && HAS_OUTPUTS)
      src = SSCS_SRC_OBUF;
    else if ((otype == SSCS_T_BUF || itype == SSCS_T_BUF) && !HAS_OUTPUTS)
      src = SSCS_SRC_IBUF;
    else if (otype == SSCS_T_LOCAL && itype == SSCS_T_LOCAL)
      src = SSCS_SRC_TIMER;
    else
      src = SSCS_SRC_NONE;
  end

  // Local timer, period follows the cycle time register
  logic [31:0] tmr_ff;
  logic        tmr_tick;
  assign tmr_tick = (tmr_ff == 32'h0);
  always_ff @(posedge clk)
  begin
    if (!rst_n || src != SSCS_SRC_TIMER)
      tmr_ff <= SSCS_R_ZERO;
    else if (tmr_tick)
      tmr_ff <= (cycle_time_ff == 32'h0) ? 32'h0 : cycle_time_ff - 1'b1;
    else
      tmr_ff <= tmr_ff - 1'b1;
  end

  logic trig;
  always_comb
  begin
    case (src)
      SSCS_SRC_TIMER: trig = tmr_tick;
      SSCS_SRC_OBUF:  trig = ob_rise;
      SSCS_SRC_IBUF:  trig = ib_rise;
      SSCS_SRC_SYNC0: trig = s0_rise;
      default:        trig = 1'b0;
    endcase
  end

  // Snapshot so a running cycle completes unchanged
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cur_otype_ff  <= 8'h00;
      cur_itype_ff  <= 8'h00;
      cur_oshift_ff <= SSCS_R_ZERO;
      cur_ishift_ff <= SSCS_R_ZERO;
      cur_ocopy_ff  <= SSCS_R_ZERO;
      cur_icopy_ff  <= SSCS_R_ZERO;
      cur_olag_ff   <= SSCS_R_ZERO;
      cur_ilag_ff   <= SSCS_R_ZERO;
      cur_min_ff    <= SSCS_R_CYCLE;
    end
    else if (trig)
    begin
      cur_otype_ff  <= otype;
      cur_itype_ff  <= itype;
      cur_oshift_ff <= (S1_REPLACE && otype == SSCS_T_DC_S1) ?
                       sync1_ivl_ff + out_lag_ff : out_shift_ff;
      cur_ishift_ff <= (S1_REPLACE && itype == SSCS_T_DC_S1) ?
                       sync1_ivl_ff + in_lag_ff : in_shift_ff;
      cur_ocopy_ff  <= out_copy_ff;
      cur_icopy_ff  <= in_copy_ff;
      cur_olag_ff   <= out_lag_ff;
      cur_ilag_ff   <= in_lag_ff;
      cur_min_ff    <= min_cycle_ff;
    end
  end

  // Drive start = offset - lag from sync point, but not before copy ends
  logic [31:0] drv_dly, lat_dly;
  always_comb
  begin
    drv_dly = (cur_oshift_ff > cur_olag_ff) ?
              cur_oshift_ff - cur_olag_ff : 32'h0;
    if (drv_dly < cur_ocopy_ff)
      drv_dly = cur_ocopy_ff;
    lat_dly = (cur_ishift_ff > cur_ilag_ff) ?
              cur_ishift_ff - cur_ilag_ff : 32'h0;
  end

  // SYNC1 as the timing reference for shifted directions when S1_REPLACE is 0
  logic t_d_ff;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      t_d_ff <= 1'b0;
    else
      t_d_ff <= trig;
  end

  logic o_ref, i_ref;
  assign o_ref = (cur_otype_ff == SSCS_T_DC_S1 && !S1_REPLACE) ?
                 s1_rise : t_d_ff;
  assign i_ref = (cur_itype_ff == SSCS_T_DC_S1 && !S1_REPLACE) ?
                 s1_rise : t_d_ff;

  logic drv_fire, val_fire, lat_fire, done_fire, rdy_fire;

  sscs_delay #(.W(32)) u_drv (.clk(clk), .rst_n(rst_n), .start(o_ref),
    .dly(drv_dly), .fire(drv_fire));
  sscs_delay #(.W(32)) u_val (.clk(clk), .rst_n(rst_n), .start(drv_fire),
    .dly(cur_olag_ff), .fire(val_fire));
  sscs_delay #(.W(32)) u_lat (.clk(clk), .rst_n(rst_n), .start(i_ref),
    .dly(lat_dly), .fire(lat_fire));
  sscs_delay #(.W(32)) u_done (.clk(clk), .rst_n(rst_n), .start(lat_fire),
    .dly(cur_ilag_ff), .fire(done_fire));
  sscs_delay #(.W(32)) u_rdy (.clk(clk), .rst_n(rst_n), .start(done_fire),
    .dly(cur_icopy_ff), .fire(rdy_fire));

  // Minimum cycle watchdog: inputs late is flagged
  logic [31:0] mc_ff;
  logic        pend_ff;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mc_ff      <= SSCS_R_ZERO;
      pend_ff    <= 1'b0;
      overrun_ff <= 1'b0;
    end
    else
    begin
      if (trig)
      begin
        mc_ff   <= min_cycle_ff;
        pend_ff <= 1'b1;
      end
      else if (rdy_fire)
        pend_ff <= 1'b0;
      else if (mc_ff != 32'h0)
        mc_ff <= mc_ff - 1'b1;
      if (pend_ff && mc_ff == 32'h0 && !rdy_fire && !trig)
        overrun_ff <= 1'b1;
      else if (wr_hit && avs_address == SSCS_A_STATUS && avs_writedata[2])
        overrun_ff <= 1'b0;
    end
  end

  // Output pulses
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cycle_start     <= 1'b0;
      out_read_start  <= 1'b0;
      out_drive_start <= 1'b0;
      out_valid       <= 1'b0;
      in_latch_start  <= 1'b0;
      in_latch_done   <= 1'b0;
      in_copy_start   <= 1'b0;
      in_data_ready   <= 1'b0;
    end
    else
    begin
      cycle_start     <= trig;
      out_read_start  <= trig;
      out_drive_start <= drv_fire;
      out_valid       <= val_fire;
      in_latch_start  <= lat_fire;
      in_latch_done   <= done_fire;
      in_copy_start   <= in_latch_done;
      in_data_ready   <= rdy_fire;
    end
  end
endmodule
`default_nettype wire

/* File: sscs_assertions.sv */
// Port checker for the sync cycle scheduler
`timescale 1ns/1ps
`default_nettype none
module sscs_assertions
  import sscs_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [11:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        obuf_event,
  input wire logic        sync0_in,
  input wire logic        out_read_start,
  input wire logic        out_drive_start,
  input wire logic        out_valid,
  input wire logic        in_latch_start,
  input wire logic        in_latch_done,
  input wire logic        in_copy_start,
  input wire logic        in_data_ready,
  input wire logic        cycle_start
);
  logic [31:0] olag_ff;
  logic [31:0] ilag_ff;
  logic [15:0] type_ff;
  logic [31:0] ocnt_ff;
  logic [31:0] icnt_ff;
  logic        done_ff;
  logic        rd_ff;
  logic        wr_ok;
  logic        rd_ok;
  assign wr_ok = avs_write && !avs_waitrequest;
  assign rd_ok = avs_read && !avs_waitrequest;
  // Mirrors of written settings; bench uses full byte lanes
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      olag_ff <= 32'h0;
      ilag_ff <= 32'h0;
      type_ff <= 16'h0;
    end
    else if (wr_ok)
    begin
      if (avs_address == SSCS_A_OUT_LAG) olag_ff <= avs_writedata;
      if (avs_address == SSCS_A_IN_LAG) ilag_ff <= avs_writedata;
      if (avs_address == SSCS_A_SYNC_TYPE) type_ff <= avs_writedata[15:0];
    end
  end
  // Cycles since the start of each lag span
  always_ff @(posedge clk)
  begin
    ocnt_ff <= out_drive_start ? 32'h1 : ocnt_ff + 32'h1;
    icnt_ff <= in_latch_start ? 32'h1 : icnt_ff + 32'h1;
    done_ff <= rst_n && (in_latch_done || (done_ff && !in_latch_start));
    rd_ff <= rst_n && (out_read_start || (rd_ff && !out_drive_start));
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence rd_go;
    $rose(avs_read);
  endsequence
  sequence one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  bus_one_wait_a: assert property (rd_go |-> one_wait)
    else $error("read not answered after one wait");
  sup_bits_a: assert property (
    rd_ok && avs_address == SSCS_A_SUPPORTED |-> avs_readdata == 32'h7)
    else $error("supported bits wrong");
  unmapped_zero_a: assert property (
    rd_ok && avs_address == 12'h100 |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  dc_trigger_a: assert property (
    $rose(sync0_in) && type_ff == 16'h0202 |-> ##3 cycle_start)
    else $error("sync0 did not start a cycle");
  buf_trigger_a: assert property (
    $rose(obuf_event) && type_ff[7:0] == 8'h01 |-> ##3 cycle_start)
    else $error("output event did not start a cycle");
  out_lag_a: assert property (
    out_valid |-> ocnt_ff == ((olag_ff == 32'h0) ? 32'h1 : olag_ff))
    else $error("output valid off its lag");
  in_lag_a: assert property (
    in_latch_done |-> icnt_ff == ((ilag_ff == 32'h0) ? 32'h1 : ilag_ff))
    else $error("latch done off its lag");
  copy_after_a: assert property (in_copy_start |-> done_ff)
    else $error("input copy before latch done");
  read_first_a: assert property (out_drive_start |-> rd_ff)
    else $error("outputs driven before buffer read");
  ready_bound_a: assert property (
    cycle_start |-> ##[1:1000] in_data_ready)
    else $error("inputs not ready within minimum cycle");
endmodule
bind sscs_scheduler sscs_assertions i_chk (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .obuf_event(obuf_event),
  .sync0_in(sync0_in), .out_read_start(out_read_start),
  .out_drive_start(out_drive_start), .out_valid(out_valid),
  .in_latch_start(in_latch_start), .in_latch_done(in_latch_done),
  .in_copy_start(in_copy_start), .in_data_ready(in_data_ready),
  .cycle_start(cycle_start));
`default_nettype wire

/* File: sscs_far_model.sv */
// Far side model: frame events and distributed clock events
`timescale 1ns/1ps
`default_nettype none
module sscs_far_model (
  input  wire logic clk,
  output var logic  obuf_event,
  output var logic  ibuf_event,
  output var logic  sync0_in,
  output var logic  sync1_in
);
  int s1_ivl = 0;
  initial
  begin
    obuf_event = 1'b0;
    ibuf_event = 1'b0;
    sync0_in = 1'b0;
    sync1_in = 1'b0;
  end
  // Pulses held 3 cycles so the 2-flop synchroniser sees them
  task automatic fire(input int sel);
    @(posedge clk);
    case (sel)
      0: sync0_in <= 1'b1;
      1: obuf_event <= 1'b1;
      default: ibuf_event <= 1'b1;
    endcase
    repeat (3) @(posedge clk);
    sync0_in <= 1'b0;
    obuf_event <= 1'b0;
    ibuf_event <= 1'b0;
    // SYNC1 trails SYNC0, the reference, by the interval
    if (sel == 0 && s1_ivl > 3)
    begin
      repeat (s1_ivl - 3) @(posedge clk);
      sync1_in <= 1'b1;
      repeat (3) @(posedge clk);
      sync1_in <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* File: sscs_scheduler_tb_top.sv */
// Register and timing tests for the sync cycle scheduler
`timescale 1ns/1ps
`default_nettype none
module sscs_scheduler_tb_top
  import sscs_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [11:0] avs_address = 12'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        obuf_event, ibuf_event, sync0_in, sync1_in;
  logic        ors, ods, ov, ils, ild, ics, idr, cs;
  int          n_errors = 0;
  int          num_checks = 0;
  int          cyc = 0, n_cs = 0, n_ov = 0, t_cs = 0, t_ov = 0;
  int          d1, d2, d3, g;
  always #4 clk = ~clk;
  sscs_far_model i_far (.clk(clk), .obuf_event(obuf_event),
    .ibuf_event(ibuf_event), .sync0_in(sync0_in), .sync1_in(sync1_in));
  sscs_scheduler i_dut (.clk(clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .obuf_event(obuf_event),
    .ibuf_event(ibuf_event), .sync0_in(sync0_in), .sync1_in(sync1_in),
    .out_read_start(ors), .out_drive_start(ods), .out_valid(ov),
    .in_latch_start(ils), .in_latch_done(ild), .in_copy_start(ics),
    .in_data_ready(idr), .cycle_start(cs));
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cs === 1'b1) begin n_cs <= n_cs + 1; t_cs <= cyc; end
    if (ov === 1'b1) begin n_ov <= n_ov + 1; t_ov <= cyc; end
  end
  task automatic conclude();
    $display("Checks %0d, errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] s);
    num_checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Holds the request until waitrequest is sampled low
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && k < 100)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 100) chk("bus answer", 32'h0, 32'h1);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rdc(input string n, input logic [11:0] a,
                     input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(n, e, q);
  endtask
  // Cycle start to output valid, in cycles
  task automatic meas(input int sel, output int dl);
    int k, n0;
    k = 0;
    n0 = n_ov;
    i_far.fire(sel);
    while (n_ov == n0 && k < 2000)
    begin
      @(posedge clk);
      k++;
    end
    dl = t_ov - t_cs;
    repeat (20) @(posedge clk);
  endtask
  task automatic starts(input string n, input int sel, input int e);
    int n0;
    n0 = n_cs;
    i_far.fire(sel);
    repeat (300) @(posedge clk);
    chk(n, e, n_cs - n0);
  endtask
  task automatic gap(output int gp);
    int k, t1;
    k = 0;
    t1 = -1;
    repeat (2)
    begin
      gp = n_cs;
      while (n_cs == gp && k < 3000)
      begin
        @(posedge clk);
        k++;
      end
      gp = t_cs - t1;
      t1 = t_cs;
    end
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc("cycle time", SSCS_A_CYCLE_TIME, 32'h3E8);
    rdc("min cycle", SSCS_A_MIN_CYCLE, 32'h3E8);
    wr(SSCS_A_SUPPORTED, 32'h0);
    rdc("supported", SSCS_A_SUPPORTED, 32'h7);
    rdc("unmapped", 12'h100, 32'h0);
    wr(SSCS_A_SYNC1_IVL, 32'h2D);
    rdc("sync1 interval", SSCS_A_SYNC1_IVL, 32'h2D);
    // Free-running timer, then a master rewrite of the period
    wr(SSCS_A_SYNC_TYPE, 32'h0);
    wr(SSCS_A_CYCLE_TIME, 32'h28);
    gap(g);
    gap(g);
    chk("timer period", 32'h28, g);
    wr(SSCS_A_CYCLE_TIME, 32'h19);
    gap(g);
    gap(g);
    chk("new period", 32'h19, g);
    wr(SSCS_A_SYNC_TYPE, 32'h0001);
    repeat (100) @(posedge clk);
    starts("obuf starts", 1, 1);
    starts("ibuf ignored", 2, 0);
    wr(SSCS_A_OUT_LAG, 32'h5);
    wr(SSCS_A_OUT_COPY, 32'h2);
    wr(SSCS_A_IN_LAG, 32'h4);
    wr(SSCS_A_IN_COPY, 32'h3);
    wr(SSCS_A_OUT_SHIFT, 32'h1E);
    wr(SSCS_A_SYNC_TYPE, 32'h0202);
    meas(0, d1);
    starts("obuf in dc", 1, 0);
    wr(SSCS_A_OUT_SHIFT, 32'h32);
    rdc("out shift", SSCS_A_OUT_SHIFT, 32'h32);
    meas(0, d2);
    chk("shift step", 32'h14, d2 - d1);
    // Interval 45 plus lag 5 must match a shift of 50
    i_far.s1_ivl = 45;
    wr(SSCS_A_SYNC_TYPE, 32'h0203);
    meas(0, d3);
    chk("sync1 shift", d2, d3);
    rdc("status", SSCS_A_STATUS, 32'h1);
    conclude();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    conclude();
  end
endmodule
`default_nettype wire
